// ==== design/drive_io_enable_fault.sv ====
`timescale 1ns/1ps

// Operation
// - input 8 is fixed to output-stage enable; software cannot reassign it
// - output stage enables only while safe torque off input is present
// - hardware enable AND software enable; software enable may be forced on
// - enable input active high; low keeps output stage off
// - enable input goes straight to logic, bypassing the periodic sample
// - relay mode bit: closed on no fault, or on no fault and enabled
// - any fault opens the relay and switches off the output stage
// - relay open always inhibits the output stage
// - relay ignores current-time limit and regeneration threshold; with the mode bit set it follows enable
// - fast input edge captures position or time within 2 us at filter codes 0 to 5
// - captured value is held until the controller reads it
// - programmable inputs are sampled every 250 us
// - each of inputs 1 to 7 has its own active level and filter setting
// - after reset inputs 1 to 7 have no function
// - two outputs with selectable source, refreshed every 250 us
// - analog input read at 16 kHz as 16 bits
// - selected measurement written to analog output at 4 kHz, 16 bits
module drive_io_enable_fault #(
  parameter int unsigned IO_CYC  = drive_io_pkg::IO_CYC,
  parameter int unsigned ADC_CYC = drive_io_pkg::ADC_CYC,
  parameter int unsigned DAC_CYC = drive_io_pkg::DAC_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [5:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [5:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [7:0]           digital_in,
  input  wire logic                 safe_torque_off_input,
  input  wire logic                 fault_req,
  input  wire drive_io_pkg::meas_t  meas,
  input  wire logic [15:0]          adc_data,
  output logic                      stage_enable,
  output logic                      relay_close,
  output logic                      programmable_output_a,
  output logic                      programmable_output_b,
  output logic                      adc_read,
  output logic [15:0]               dac_data,
  output logic                      dac_load,
  output logic                      irq
);

  if (IO_CYC < 2 || IO_CYC > 65536) begin : g_chk_io
    $error("IO_CYC out of range");
  end
  if (ADC_CYC < 2 || ADC_CYC > 65536) begin : g_chk_adc
    $error("ADC_CYC out of range");
  end
  if (DAC_CYC < 2 || DAC_CYC > 65536) begin : g_chk_dac
    $error("DAC_CYC out of range");
  end
  if (drive_io_pkg::FILT_BASE_CYC + 4 > drive_io_pkg::LATCH_MAX_CYC)
  begin : g_chk_lat
    $error("base filter too slow for latch");
  end

  typedef struct packed {
    logic [7:0]       s1;
    logic [7:0]       s2;
    logic             sto1;
    logic             sto2;
    logic [6:0]       filt;
    logic [6:0][10:0] fcnt;
    logic [6:0]       act_p;
    logic [6:0]       smp;
    logic [15:0]      io_cnt;
    logic [15:0]      adc_cnt;
    logic [15:0]      dac_cnt;
    logic [6:0]       ctrl;
    logic [13:0]      func;
    logic [6:0]       inv;
    logic [20:0]      fsel;
    logic [3:0]       osel;
    logic [3:0]       lcfg;
    logic [3:0]       mask;
    logic [3:0]       ist;
    logic [1:0][31:0] lat;
    logic [1:0]       lval;
    logic [15:0]      adc;
    logic             adc_rd;
    logic [15:0]      dac;
    logic             dac_ld;
    logic             out_a;
    logic             out_b;
    logic             stage;
    logic             relay;
    logic             fault;
    logic             irq;
    logic             aw_ok;
    logic             w_ok;
    logic [5:0]       waddr;
    logic [31:0]      wdat;
    logic [3:0]       wstb;
    logic             awrdy;
    logic             wrdy;
    logic             arrdy;
    logic             bval;
    logic [1:0]       bres;
    logic             rval;
    logic [31:0]      rdat;
    logic [1:0]       rres;
  } st_t;

  st_t q;
  st_t d;

  function automatic logic mapped(input logic [5:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= drive_io_pkg::OFS_ADC);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[8*b +: 8] = n[8*b +: 8];
      end
    end
  endfunction

  function automatic logic pick(input logic [1:0] sel,
                                input logic       stage_on,
                                input logic       no_fault,
                                input logic       sw);
    case (sel)
      2'h0:    pick = 1'b0;
      2'h1:    pick = stage_on;
      2'h2:    pick = no_fault;
      default: pick = sw;
    endcase
  endfunction

  always_comb begin
    logic [10:0] thr;
    logic [6:0]  act;
    logic [6:0]  used;
    logic        ext_f;
    logic        fault;
    logic        hw_en;
    logic        sw_en;
    logic        drv_en;
    logic [3:0]  ev;
    logic [3:0]  clr;
    logic [1:0]  edg;
    logic [31:0] w;
    thr    = '0;
    act    = '0;
    used   = '0;
    ext_f  = 1'b0;
    fault  = 1'b0;
    hw_en  = 1'b0;
    sw_en  = 1'b0;
    drv_en = 1'b0;
    ev     = '0;
    clr    = '0;
    edg    = '0;
    w      = '0;
    d      = q;

    d.s1   = digital_in;
    d.s2   = q.s1;
    d.sto1 = safe_torque_off_input;
    d.sto2 = q.sto1;

    // per-input filter, length doubles per code step
    for (int i = 0; i < 7; i++) begin
      thr = 11'(drive_io_pkg::FILT_BASE_CYC) << q.fsel[3*i +: 3];
      if (q.s2[i] == q.filt[i]) begin
        d.fcnt[i] = '0;
      end else if (q.fcnt[i] >= thr - 11'h001) begin
        d.filt[i] = q.s2[i];
        d.fcnt[i] = '0;
      end else begin
        d.fcnt[i] = q.fcnt[i] + 11'h001;
      end
      act[i]  = q.filt[i] ^ q.inv[i];
      used[i] = q.func[2*i +: 2] != drive_io_pkg::FN_OFF;
      if (q.func[2*i +: 2] == drive_io_pkg::FN_FAULT && act[i]) begin
        ext_f = 1'b1;
      end
    end
    act    = act & used;
    d.act_p = act;

    // enable chain: no sampling, only the synchroniser
    hw_en  = q.s2[7];
    sw_en  = q.ctrl[drive_io_pkg::CTRL_SW_EN] |
             q.ctrl[drive_io_pkg::CTRL_SW_FORCE];
    drv_en = hw_en & sw_en & q.sto2;
    fault  = fault_req | ext_f;
    d.fault = fault;
    // relay sees only fault, mode and drive enable, never limits or thresholds
    d.relay = !fault &
              (!q.ctrl[drive_io_pkg::CTRL_RLY_MODE] | drv_en);
    d.stage = drv_en & !fault & d.relay;

    // periodic input sample and output refresh
    if (q.io_cnt == 16'(IO_CYC - 1)) begin
      d.io_cnt = '0;
      d.smp    = act;
      d.out_a  = pick(q.osel[1:0], q.stage, q.relay,
                      q.ctrl[drive_io_pkg::CTRL_OUTA_SW]);
      d.out_b  = pick(q.osel[3:2], q.stage, q.relay,
                      q.ctrl[drive_io_pkg::CTRL_OUTB_SW]);
    end else begin
      d.io_cnt = q.io_cnt + 16'h0001;
    end

    // analog input strobe
    d.adc_rd = 1'b0;
    if (q.adc_cnt == 16'(ADC_CYC - 1)) begin
      d.adc_cnt = '0;
      d.adc     = adc_data;
      d.adc_rd  = 1'b1;
    end else begin
      d.adc_cnt = q.adc_cnt + 16'h0001;
    end

    // analog output update
    d.dac_ld = 1'b0;
    if (q.dac_cnt == 16'(DAC_CYC - 1)) begin
      d.dac_cnt = '0;
      d.dac_ld  = 1'b1;
      case (q.ctrl[drive_io_pkg::CTRL_DAC_SEL +: 2])
        2'h0:    d.dac = q.ctrl[drive_io_pkg::CTRL_DAC_SEL] ?
                         meas.position[15:0] : meas.velocity;
        2'h1:    d.dac = meas.position[15:0];
        2'h2:    d.dac = q.adc;
        default: d.dac = q.lat[0][15:0];
      endcase
    end else begin
      d.dac_cnt = q.dac_cnt + 16'h0001;
    end

    // bus read, latch registers free on read
    if (q.rval && rready) begin
      d.rval = 1'b0;
    end
    if (arvalid && q.arrdy) begin
      d.rval = 1'b1;
      d.rres = mapped(araddr) ? 2'h0 : 2'h2;
      case (araddr)
        drive_io_pkg::OFS_CTRL:      d.rdat = 32'(q.ctrl);
        drive_io_pkg::OFS_STATUS:    d.rdat = {17'h00000, q.smp, 1'b0,
                                              q.lval, q.fault, q.sto2,
                                              q.s2[7], q.relay, q.stage};
        drive_io_pkg::OFS_IRQ_STAT:  d.rdat = 32'(q.ist);
        drive_io_pkg::OFS_IRQ_MASK:  d.rdat = 32'(q.mask);
        drive_io_pkg::OFS_IN_FUNC:   d.rdat = 32'(q.func);
        drive_io_pkg::OFS_IN_INV:    d.rdat = 32'(q.inv);
        drive_io_pkg::OFS_IN_FILT:   d.rdat = 32'(q.fsel);
        drive_io_pkg::OFS_OUT_SEL:   d.rdat = 32'(q.osel);
        drive_io_pkg::OFS_LATCH_CFG: d.rdat = 32'(q.lcfg);
        drive_io_pkg::OFS_LATCH0: begin
          d.rdat    = q.lat[0];
          d.lval[0] = 1'b0;
        end
        drive_io_pkg::OFS_LATCH1: begin
          d.rdat    = q.lat[1];
          d.lval[1] = 1'b0;
        end
        drive_io_pkg::OFS_ADC:       d.rdat = 32'(q.adc);
        default:                     d.rdat = '0;
      endcase
    end

    // fast capture; a held value is kept until read
    for (int i = 0; i < 2; i++) begin
      edg[i] = q.lcfg[2+i] ? (q.act_p[i] & !act[i])
                           : (!q.act_p[i] & act[i]);
      if (edg[i] && !q.lval[i] &&
          q.func[2*i +: 2] == drive_io_pkg::FN_LATCH) begin
        d.lat[i]  = q.lcfg[i] ? meas.itime : meas.position;
        d.lval[i] = 1'b1;
        ev[i]     = 1'b1;
      end
    end
    ev[2] = fault & !q.fault;
    ev[3] = q.stage & !d.stage;

    // bus write
    if (q.bval && bready) begin
      d.bval = 1'b0;
    end
    if (awvalid && q.awrdy) begin
      d.aw_ok = 1'b1;
      d.waddr = awaddr;
    end
    if (wvalid && q.wrdy) begin
      d.w_ok = 1'b1;
      d.wdat = wdata;
      d.wstb = wstrb;
    end
    if (q.aw_ok && q.w_ok && !q.bval) begin
      d.aw_ok = 1'b0;
      d.w_ok  = 1'b0;
      d.bval  = 1'b1;
      d.bres  = mapped(q.waddr) ? 2'h0 : 2'h2;
      case (q.waddr)
        drive_io_pkg::OFS_CTRL: begin
          w      = merge(32'(q.ctrl), q.wdat, q.wstb);
          d.ctrl = w[6:0];
        end
        drive_io_pkg::OFS_IRQ_STAT: begin
          w   = merge('0, q.wdat, q.wstb);
          clr = w[3:0];
        end
        drive_io_pkg::OFS_IRQ_MASK: begin
          w      = merge(32'(q.mask), q.wdat, q.wstb);
          d.mask = w[3:0];
        end
        drive_io_pkg::OFS_IN_FUNC: begin
          // only inputs 1 to 7 have fields here
          w      = merge(32'(q.func), q.wdat, q.wstb);
          d.func = w[13:0];
        end
        drive_io_pkg::OFS_IN_INV: begin
          w     = merge(32'(q.inv), q.wdat, q.wstb);
          d.inv = w[6:0];
        end
        drive_io_pkg::OFS_IN_FILT: begin
          w      = merge(32'(q.fsel), q.wdat, q.wstb);
          d.fsel = w[20:0];
        end
        drive_io_pkg::OFS_OUT_SEL: begin
          w      = merge(32'(q.osel), q.wdat, q.wstb);
          d.osel = w[3:0];
        end
        drive_io_pkg::OFS_LATCH_CFG: begin
          w      = merge(32'(q.lcfg), q.wdat, q.wstb);
          d.lcfg = w[3:0];
        end
        default: w = '0;
      endcase
    end

    // set wins over a same-cycle clear
    d.ist   = (q.ist & ~clr) | ev;
    d.irq   = |(d.ist & d.mask);
    d.awrdy = !d.aw_ok && !d.bval;
    d.wrdy  = !d.w_ok && !d.bval;
    d.arrdy = !d.rval;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.ctrl <= drive_io_pkg::RST_CTRL;
      q.func <= drive_io_pkg::RST_FUNC;
      q.inv  <= drive_io_pkg::RST_INV;
      q.fsel <= drive_io_pkg::RST_FILT;
      q.osel <= drive_io_pkg::RST_OSEL;
      q.lcfg <= drive_io_pkg::RST_LCFG;
      q.mask <= drive_io_pkg::RST_MASK;
    end else begin
      q <= d;
    end
  end

  assign awready               = q.awrdy;
  assign wready                = q.wrdy;
  assign bvalid                = q.bval;
  assign bresp                 = q.bres;
  assign arready               = q.arrdy;
  assign rvalid                = q.rval;
  assign rdata                 = q.rdat;
  assign rresp                 = q.rres;
  assign stage_enable          = q.stage;
  assign relay_close           = q.relay;
  assign programmable_output_a = q.out_a;
  assign programmable_output_b = q.out_b;
  assign adc_read              = q.adc_rd;
  assign dac_data              = q.dac;
  assign dac_load              = q.dac_ld;
  assign irq                   = q.irq;

endmodule

// ==== shared/drive_io_pkg.sv ====
package drive_io_pkg;

  localparam int unsigned ADDR_W = 6;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL      = 6'h00;
  localparam logic [5:0] OFS_STATUS    = 6'h04;
  localparam logic [5:0] OFS_IRQ_STAT  = 6'h08;
  localparam logic [5:0] OFS_IRQ_MASK  = 6'h0c;
  localparam logic [5:0] OFS_IN_FUNC   = 6'h10;
  localparam logic [5:0] OFS_IN_INV    = 6'h14;
  localparam logic [5:0] OFS_IN_FILT   = 6'h18;
  localparam logic [5:0] OFS_OUT_SEL   = 6'h1c;
  localparam logic [5:0] OFS_LATCH_CFG = 6'h20;
  localparam logic [5:0] OFS_LATCH0    = 6'h24;
  localparam logic [5:0] OFS_LATCH1    = 6'h28;
  localparam logic [5:0] OFS_ADC       = 6'h2c;

  // ctrl fields
  localparam int unsigned CTRL_SW_EN    = 0;
  localparam int unsigned CTRL_SW_FORCE = 1;
  localparam int unsigned CTRL_RLY_MODE = 2;
  localparam int unsigned CTRL_OUTA_SW  = 3;
  localparam int unsigned CTRL_OUTB_SW  = 4;
  localparam int unsigned CTRL_DAC_SEL  = 5;

  // reset values
  localparam logic [6:0]  RST_CTRL  = 7'h00;
  localparam logic [13:0] RST_FUNC  = 14'h0000;
  localparam logic [6:0]  RST_INV   = 7'h00;
  localparam logic [20:0] RST_FILT  = 21'h000000;
  localparam logic [3:0]  RST_OSEL  = 4'h0;
  localparam logic [3:0]  RST_LCFG  = 4'h0;
  localparam logic [3:0]  RST_MASK  = 4'h0;

  // input functions
  typedef enum logic [1:0] {
    FN_OFF   = 2'h0,
    FN_PLAIN = 2'h1,
    FN_FAULT = 2'h2,
    FN_LATCH = 2'h3
  } in_fn_t;

  // timing
  localparam int unsigned CLK_KHZ       = 200000;
  localparam int unsigned FILT_NS       = 40;
  localparam int unsigned FILT_BASE_CYC = (FILT_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned LATCH_MAX_NS  = 2000;
  localparam int unsigned LATCH_MAX_CYC = LATCH_MAX_NS * CLK_KHZ / 1000000;
  localparam int unsigned IO_PERIOD_US  = 250;
  localparam int unsigned IO_CYC        = IO_PERIOD_US * CLK_KHZ / 1000;
  localparam int unsigned ADC_RATE_KHZ  = 16;
  localparam int unsigned ADC_CYC       = CLK_KHZ / ADC_RATE_KHZ;
  localparam int unsigned DAC_RATE_KHZ  = 4;
  localparam int unsigned DAC_CYC       = CLK_KHZ / DAC_RATE_KHZ;

  typedef struct packed {
    logic [31:0] position;
    logic [31:0] itime;
    logic [15:0] velocity;
  } meas_t;

endpackage

// ==== bench/field_wiring.sv ====
`timescale 1ns/1ps
module field_wiring (
  input  wire logic        aclk,
  input  wire logic [7:0]  pins_set,
  input  wire logic        sto_set,
  input  wire logic [15:0] adc_level,
  input  wire logic        adc_read,
  output logic [7:0]       digital_in,
  output logic             safe_torque_off_input,
  output logic [15:0]      adc_data
);
  // each read strobe starts a conversion, so the block collects the
  // previous result at its strobe edge: one sample of latency
  always_ff @(posedge aclk) begin
    if (adc_read) begin
      adc_data <= adc_level;
    end
  end
  // wiring is asynchronous to the design, so pins follow with no delay
  assign digital_in = pins_set;
  assign safe_torque_off_input = sto_set;
endmodule

// ==== bench/drive_io_enable_fault_asserts.sv ====
`timescale 1ns/1ps
module drive_io_asserts #(
  parameter int unsigned ADC_CYC = drive_io_pkg::ADC_CYC
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  digital_in,
  input wire logic        safe_torque_off_input,
  input wire logic        fault_req,
  input wire logic        stage_enable,
  input wire logic        relay_close,
  input wire logic        adc_read,
  input wire logic [15:0] dac_data,
  input wire logic        dac_load
);
  logic [15:0] adc_cnt_q;
  logic        adc_seen_q;

  // first pulse after reset has no reference, so only gaps are judged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_cnt_q  <= 16'h0000;
      adc_seen_q <= 1'b0;
    end else if (adc_read) begin
      adc_cnt_q  <= 16'h0000;
      adc_seen_q <= 1'b1;
    end else begin
      adc_cnt_q  <= adc_cnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_relay_gates_stage: assert property (
    stage_enable |-> relay_close)
    else $error("stage on while relay open");
  a_fault_opens_relay: assert property (
    fault_req |=> !relay_close)
    else $error("relay closed during fault");
  a_fault_stops_stage: assert property (
    fault_req |=> !stage_enable)
    else $error("stage on during fault");
  a_sto_gates_stage: assert property (
    !safe_torque_off_input [*3] |=> !stage_enable)
    else $error("stage on without sto");
  a_hw_enable_low: assert property (
    !digital_in[7] [*3] |=> !stage_enable)
    else $error("stage on with enable pin low");
  a_adc_cadence: assert property (
    (adc_read && adc_seen_q) |-> adc_cnt_q == 16'(ADC_CYC - 1))
    else $error("adc read spacing wrong");
  a_adc_no_gap: assert property (
    adc_seen_q |-> adc_cnt_q < 16'(ADC_CYC))
    else $error("adc read missing");
  a_dac_on_load: assert property (
    $changed(dac_data) |-> dac_load)
    else $error("dac data moved without load");
endmodule

bind drive_io_enable_fault drive_io_asserts #(.ADC_CYC(ADC_CYC)) chk (
  .aclk                  (aclk),
  .aresetn               (aresetn),
  .digital_in            (digital_in),
  .safe_torque_off_input (safe_torque_off_input),
  .fault_req             (fault_req),
  .stage_enable          (stage_enable),
  .relay_close           (relay_close),
  .adc_read              (adc_read),
  .dac_data              (dac_data),
  .dac_load              (dac_load)
);

// ==== bench/drive_io_enable_fault_tb_top.sv ====
`timescale 1ns/1ps
module drive_io_enable_fault_tb_top;
  localparam int IO = 40;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, safe_torque_off_input, fault_req;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  digital_in, pins_set;
  logic        sto_set, stage_enable, relay_close, adc_read, dac_load, irq;
  logic        programmable_output_a, programmable_output_b;
  logic [15:0] adc_data, adc_level, dac_data;
  drive_io_pkg::meas_t meas;
  int bad_count, total_checks;

  drive_io_enable_fault #(.IO_CYC(IO), .ADC_CYC(20), .DAC_CYC(30)) uut (.*);
  field_wiring far (
    .aclk                  (aclk),
    .pins_set              (pins_set),
    .sto_set               (sto_set),
    .adc_level             (adc_level),
    .adc_read              (adc_read),
    .digital_in            (digital_in),
    .safe_torque_off_input (safe_torque_off_input),
    .adc_data              (adc_data)
  );

  always #2.5 aclk = ~aclk;

  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, e, input string m);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!(bvalid && !awvalid && !wvalid) && n < 200);
    // bready stays up between writes, no double drive in one step
    if (n >= 200) begin
      bad_count++;
      $display("[ERR] %0t write timed out", $time);
    end
    r = bresp;
  endtask

  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!(rvalid && !arvalid) && n < 200);
    if (n >= 200) begin
      bad_count++;
      $display("[ERR] %0t read timed out", $time);
    end
    d = rdata;
    r = rresp;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_word({30'h0, r}, 32'h0, "wr resp");
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_word(d & m, e, "rd data");
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(drive_io_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
    rd_chk(drive_io_pkg::OFS_IN_FUNC, 32'hffffffff, 32'h0);
    axi_rd(6'h30, d, r);
    chk_word({30'h0, r}, 32'h2, "unmapped rd");
  endtask

  task automatic t_enable();
    chk_bit(stage_enable, 1'b0, "sw off");
    wr(drive_io_pkg::OFS_CTRL, 32'h1);
    tick(4);
    chk_bit(stage_enable, 1'b1, "all on");
    pins_set[7] <= 1'b0;
    tick(4);
    chk_bit(stage_enable, 1'b0, "hw off fast");
    // field above input 7 tries to make input 8 a fault input
    wr(drive_io_pkg::OFS_IN_FUNC, 32'h00009555);
    pins_set[7] <= 1'b1;
    tick(4);
    chk_bit(stage_enable, 1'b1, "pin 8 fixed");
    wr(drive_io_pkg::OFS_IN_FUNC, 32'h0);
    wr(drive_io_pkg::OFS_CTRL, 32'h2);
    tick(2);
    chk_bit(stage_enable, 1'b1, "forced sw");
    sto_set <= 1'b0;
    tick(4);
    chk_bit(stage_enable, 1'b0, "sto low");
    sto_set <= 1'b1;
  endtask

  task automatic t_relay();
    pins_set[7] <= 1'b0;
    tick(4);
    chk_bit(relay_close, 1'b1, "mode0 no enable");
    fault_req <= 1'b1;
    tick(2);
    chk_bit(relay_close, 1'b0, "fault relay");
    fault_req <= 1'b0;
    wr(drive_io_pkg::OFS_CTRL, 32'h6);
    tick(2);
    chk_bit(relay_close, 1'b0, "mode1 disabled");
    pins_set[7] <= 1'b1;
    tick(6);
    chk_bit(relay_close, 1'b1, "mode1 enabled");
    chk_bit(stage_enable, 1'b1, "mode1 stage");
  endtask

  task automatic t_irq();
    wr(drive_io_pkg::OFS_IRQ_STAT, 32'hf);
    wr(drive_io_pkg::OFS_IRQ_MASK, 32'h4);
    fault_req <= 1'b1;
    tick(1);
    fault_req <= 1'b0;
    tick(3);
    chk_bit(irq, 1'b1, "irq set");
    wr(drive_io_pkg::OFS_IRQ_STAT, 32'hf);
    tick(2);
    chk_bit(irq, 1'b0, "irq cleared");
    wr(drive_io_pkg::OFS_IRQ_MASK, 32'h0);
    fault_req <= 1'b1;
    tick(1);
    fault_req <= 1'b0;
    tick(3);
    chk_bit(irq, 1'b0, "irq masked");
    rd_chk(drive_io_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
  endtask

  task automatic t_latch();
    logic [31:0] d;
    logic [1:0]  r;
    int n;
    n = 0;
    meas.position <= 32'h1234abcd;
    wr(drive_io_pkg::OFS_IN_FUNC, 32'h3);
    wr(drive_io_pkg::OFS_LATCH_CFG, 32'h0);
    pins_set[0] <= 1'b1;
    do begin
      axi_rd(drive_io_pkg::OFS_STATUS, d, r);
      n++;
    end while (d[5] !== 1'b1 && n < 100);
    // a hundred polls stay well inside the capture window
    chk_bit(d[5], 1'b1, "latch valid");
    meas.position <= 32'h0badf00d;
    pins_set[0] <= 1'b0;
    tick(20);
    pins_set[0] <= 1'b1;
    tick(30);
    rd_chk(drive_io_pkg::OFS_LATCH0, 32'hffffffff, 32'h1234abcd);
    rd_chk(drive_io_pkg::OFS_STATUS, 32'h20, 32'h0);
    // input 2, time source, captures only when becoming inactive
    wr(drive_io_pkg::OFS_IN_FUNC, 32'hc);
    wr(drive_io_pkg::OFS_LATCH_CFG, 32'ha);
    meas.itime <= 32'h00c0ffee;
    pins_set[1] <= 1'b1;
    tick(30);
    rd_chk(drive_io_pkg::OFS_STATUS, 32'h40, 32'h0);
    pins_set[1] <= 1'b0;
    tick(30);
    rd_chk(drive_io_pkg::OFS_LATCH1, 32'hffffffff, 32'h00c0ffee);
  endtask

  task automatic t_inputs();
    wr(drive_io_pkg::OFS_IN_FUNC, 32'h10);
    wr(drive_io_pkg::OFS_IN_INV, 32'h4);
    pins_set[3:2] <= 2'b10;
    tick(3 * IO);
    rd_chk(drive_io_pkg::OFS_STATUS, 32'hc00, 32'h400);
    pins_set[2] <= 1'b1;
    tick(3 * IO);
    rd_chk(drive_io_pkg::OFS_STATUS, 32'hc00, 32'h0);
  endtask

  task automatic t_outputs();
    wr(drive_io_pkg::OFS_OUT_SEL, 32'h7);
    wr(drive_io_pkg::OFS_CTRL, 32'h0a);
    tick(IO + 5);
    chk_bit(programmable_output_a, 1'b1, "out a sw");
    chk_bit(programmable_output_b, 1'b1, "out b stage");
  endtask

  task automatic t_analog();
    adc_level <= 16'h5a3c;
    // one strobe to convert, the next to collect
    tick(45);
    rd_chk(drive_io_pkg::OFS_ADC, 32'hffff, 32'h5a3c);
    wr(drive_io_pkg::OFS_CTRL, 32'h40);
    tick(70);
    chk_word({16'h0, dac_data}, 32'h5a3c, "dac data");
  endtask

  initial begin
    aclk = 1'b0;
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, araddr, wdata} <= 44'h0;
    wstrb <= 4'hf;
    pins_set <= 8'h80;
    sto_set <= 1'b1;
    fault_req <= 1'b0;
    meas <= '0;
    adc_level <= 16'h0000;
    tick(5);
    aresetn <= 1'b1;
    tick(2);
    t_reset();
    t_enable();
    t_relay();
    t_irq();
    t_latch();
    t_inputs();
    t_outputs();
    t_analog();
    end_of_test();
  end

  initial begin
    tick(20000);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
